// ### lcd_pkg.sv
// Package for the LCD pixel and control register bank.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.
package lcd_pkg;

  // Register byte offsets on the APB
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_PHASE    = 12'h004;
  localparam logic [11:0] OFF_SE0      = 12'h008;
  localparam logic [11:0] OFF_IRQ_ST   = 12'h014;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h018;
  localparam logic [11:0] OFF_PIX      = 12'h040;
  localparam logic [11:0] WORD_BYTES   = 12'h004;

  // Array sizes
  localparam int SEG_GROUPS = 3;
  localparam int COMMONS    = 4;
  localparam int PIX_REGS   = SEG_GROUPS * COMMONS;

  // Main control field positions and reset value
  localparam int CTRL_ON      = 7;
  localparam int CTRL_SLP_DIS = 6;
  localparam int CTRL_FAULT   = 5;
  localparam int CTRL_UNUSED  = 4;
  localparam int CTRL_CS_LSB  = 2;
  localparam int CTRL_MUX_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h03;

  // Phase register field positions and reset value
  localparam int PH_WAVE_B  = 7;
  localparam int PH_WA      = 5;
  localparam int PH_PRE_LSB = 0;
  localparam logic [7:0] PHASE_RESET = 8'h00;

  // Interrupt status bits
  localparam int IRQ_FAULT    = 0;
  localparam int IRQ_UNMAPPED = 1;
  localparam int IRQ_N        = 2;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic       driver_on;
    logic       sleep_disable;
    logic [1:0] clock_src;
    logic [1:0] multiplex_sel;
    logic       waveform_b;
    logic [3:0] prescale;
  } lcd_cfg_t;

  typedef enum logic [2:0] {
    K_NONE     = 3'b000,
    K_CTRL     = 3'b001,
    K_PHASE    = 3'b010,
    K_SE       = 3'b011,
    K_IRQ_ST   = 3'b100,
    K_IRQ_MASK = 3'b101,
    K_PIX      = 3'b110
  } reg_kind_t;

endpackage

// ### pixel_mem.sv
// Pixel memory: one write port, two registered read ports.
// Assumes one clock, synchronous reset and a freezing clock enable.
`timescale 1ns/1ps
module pixel_mem #(
  parameter int DEPTH = 12,
  parameter int WIDTH = 8,
  parameter int AW    = 4
) (
  // Clock and control
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read ports
  input  wire logic [AW-1:0]    raddr_a,
  output logic      [WIDTH-1:0] rdata_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_b
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Storage, cleared so absent entries read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
    end else if (ce && we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered reads
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else if (ce) begin
      rdata_a <= (int'(raddr_a) < DEPTH) ? mem[raddr_a] : '0;
      rdata_b <= (int'(raddr_b) < DEPTH) ? mem[raddr_b] : '0;
    end
  end
endmodule

// ### irq_unit.sv
// Sticky interrupt status with mask and one level output.
// Assumes event pulses on the same clock; status clears by writing ones.
`timescale 1ns/1ps
module irq_unit #(
  parameter int N = 2
) (
  // Clock and control
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // Events and software access
  input  wire logic [N-1:0] ev,
  input  wire logic         wr_status,
  input  wire logic         wr_mask,
  input  wire logic [N-1:0] wdata,
  // State
  output logic      [N-1:0] status_reg,
  output logic      [N-1:0] mask_reg,
  output logic              irq_reg
);
  logic [N-1:0] status_next;

  // A new event wins over a clear in the same cycle
  always_comb begin
    status_next = (status_reg & ~(wr_status ? wdata : '0)) | ev;
  end

  // Status, mask and interrupt line
  always_ff @(posedge clk) begin
    if (rst) begin
      status_reg <= '0;
      mask_reg   <= '0;
      irq_reg    <= 1'b0;
    end else if (ce) begin
      status_reg <= status_next;
      if (wr_mask) mask_reg <= wdata;
      irq_reg <= |(status_next & (wr_mask ? wdata : mask_reg));
    end
  end
endmodule

// ### lcd_regs.sv
// LCD driver register bank: control, phase, segment enables, pixel data.
// Assumes an APB master on clk; waveform engine reads pixels on the display port.
`timescale 1ns/1ps
module lcd_regs
  import lcd_pkg::*;
#(
  parameter bit LARGE = 1'b1
) (
  // Clock, reset, enable
  input  wire logic     clk,
  input  wire logic     rst,
  input  wire logic     ce,
  // APB slave
  input  wire apb_req_t apb_req,
  output logic          pready,
  output logic [31:0]   prdata,
  output logic          pslverr,
  // Chip and waveform engine status
  input  wire logic     chip_sleep,
  input  wire logic     write_allow,
  // Display read port
  input  wire logic [3:0] disp_idx,
  output logic [7:0]    disp_pixels,
  // Configuration to the panel logic
  output lcd_cfg_t      cfg,
  output logic          write_fault_flag,
  output logic          lcd_active,
  output logic [23:0]   segment_pin_assign,
  // Interrupt
  output logic          irq
);

  // Elaboration check on the variant
  if (LARGE !== 1'b0 && LARGE !== 1'b1) begin : g_bad_variant
    $error("LARGE must be 0 or 1");
  end

  // Pixel register index from a byte address
  function automatic logic [3:0] pix_index(input logic [11:0] a);
    logic [11:0] d;
    d = (a - OFF_PIX) >> 2;
    return d[3:0];
  endfunction

  // Segment group of a pixel index: index = 3 * common + group
  function automatic logic [1:0] pix_group(input logic [3:0] idx);
    return 2'(idx % 4'(SEG_GROUPS));
  endfunction

  // Register kind decoded from a byte address
  function automatic reg_kind_t kind_of(input logic [11:0] a);
    reg_kind_t k;
    k = K_NONE;
    if (a[1:0] == 2'b00) begin
      if (a == OFF_CTRL) k = K_CTRL;
      else if (a == OFF_PHASE) k = K_PHASE;
      else if (a >= OFF_SE0 && a < OFF_SE0 + 12'(SEG_GROUPS) * WORD_BYTES) k = K_SE;
      else if (a == OFF_IRQ_ST) k = K_IRQ_ST;
      else if (a == OFF_IRQ_MASK) k = K_IRQ_MASK;
      else if (a >= OFF_PIX && a < OFF_PIX + 12'(PIX_REGS) * WORD_BYTES) k = K_PIX;
    end
    return k;
  endfunction

  // Whether a segment group exists on this variant
  function automatic logic group_present(input logic [1:0] grp);
    return (grp < 2'(SEG_GROUPS - 1)) || LARGE;
  endfunction

  reg_kind_t  kind;
  logic [1:0] se_grp;
  logic [3:0] pidx;
  logic       access;
  logic       done;
  logic       wr_done;
  logic       pix_wr;
  logic       pix_allowed;
  logic       fault_ev;
  logic       unmapped_ev;
  logic [7:0] mem_bus_rdata;
  logic [7:0] seg_en_reg [SEG_GROUPS];
  logic [7:0] ctrl_rd;
  logic [7:0] phase_rd;
  logic [31:0] prdata_next;
  logic [IRQ_N-1:0] irq_status;
  logic [IRQ_N-1:0] irq_mask;
  logic       irq_wire;

  // Address decode and transfer strobes
  always_comb begin
    kind        = kind_of(apb_req.paddr);
    se_grp      = 2'((apb_req.paddr - OFF_SE0) >> 2);
    pidx        = pix_index(apb_req.paddr);
    access      = apb_req.psel && apb_req.penable;
    done        = ce && access && pready;
    wr_done     = done && apb_req.pwrite;
    pix_allowed = !cfg.driver_on || write_allow;
    pix_wr      = wr_done && (kind == K_PIX) && group_present(pix_group(pidx)) && pix_allowed;
    fault_ev    = wr_done && (kind == K_PIX) && !pix_allowed;
    unmapped_ev = done && (kind == K_NONE);
  end

  // APB ready: one wait state, then answer
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= access && !pready;
    end
  end

  // Main control fields
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.driver_on     <= CTRL_RESET[CTRL_ON];
      cfg.sleep_disable <= CTRL_RESET[CTRL_SLP_DIS];
      cfg.clock_src     <= CTRL_RESET[CTRL_CS_LSB +: 2];
      cfg.multiplex_sel <= CTRL_RESET[CTRL_MUX_LSB +: 2];
    end else if (ce && wr_done && kind == K_CTRL) begin
      cfg.driver_on     <= apb_req.pwdata[CTRL_ON];
      cfg.sleep_disable <= apb_req.pwdata[CTRL_SLP_DIS];
      cfg.clock_src     <= apb_req.pwdata[CTRL_CS_LSB +: 2];
      cfg.multiplex_sel <= apb_req.pwdata[CTRL_MUX_LSB +: 2];
    end
  end

  // Phase register: prescaler and waveform type
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg.waveform_b <= PHASE_RESET[PH_WAVE_B];
      cfg.prescale   <= PHASE_RESET[PH_PRE_LSB +: 4];
    end else if (ce && wr_done && kind == K_PHASE) begin
      cfg.waveform_b <= apb_req.pwdata[PH_WAVE_B];
      cfg.prescale   <= apb_req.pwdata[PH_PRE_LSB +: 4];
    end
  end

  // Write fault flag: set by a refused pixel write, cleared by writing zero
  always_ff @(posedge clk) begin
    if (rst) begin
      write_fault_flag <= CTRL_RESET[CTRL_FAULT];
    end else if (ce) begin
      if (fault_ev) begin
        write_fault_flag <= 1'b1;
      end else if (wr_done && kind == K_CTRL && !apb_req.pwdata[CTRL_FAULT]) begin
        write_fault_flag <= 1'b0;
      end
    end
  end

  // Panel running: on, and not stopped by sleep
  always_ff @(posedge clk) begin
    if (rst) begin
      lcd_active <= 1'b0;
    end else if (ce) begin
      lcd_active <= cfg.driver_on && !(chip_sleep && cfg.sleep_disable);
    end
  end

  // Segment enable registers, one per group
  for (genvar g = 0; g < SEG_GROUPS; g++) begin : g_seg
    always_ff @(posedge clk) begin
      if (rst) begin
        seg_en_reg[g] <= 8'h00;
      end else if (ce && wr_done && kind == K_SE && se_grp == 2'(g)
                   && group_present(2'(g))) begin
        seg_en_reg[g] <= apb_req.pwdata[7:0];
      end
    end
    assign segment_pin_assign[8*g +: 8] = seg_en_reg[g];
  end

  // Pixel storage; a one bit is a dark pixel for the waveform engine
  pixel_mem #(
    .DEPTH (PIX_REGS),
    .WIDTH (8),
    .AW    (4)
  ) u_mem (
    .clk     (clk),
    .rst     (rst),
    .ce      (ce),
    .we      (pix_wr),
    .waddr   (pidx),
    .wdata   (apb_req.pwdata[7:0]),
    .raddr_a (pidx),
    .rdata_a (mem_bus_rdata),
    .raddr_b (disp_idx),
    .rdata_b (disp_pixels)
  );

  // Sticky events with mask
  irq_unit #(
    .N (IRQ_N)
  ) u_irq (
    .clk        (clk),
    .rst        (rst),
    .ce         (ce),
    .ev         ({unmapped_ev, fault_ev}),
    .wr_status  (wr_done && kind == K_IRQ_ST),
    .wr_mask    (wr_done && kind == K_IRQ_MASK),
    .wdata      (apb_req.pwdata[IRQ_N-1:0]),
    .status_reg (irq_status),
    .mask_reg   (irq_mask),
    .irq_reg    (irq_wire)
  );
  assign irq = irq_wire;

  // Read views of control and phase
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[CTRL_ON]             = cfg.driver_on;
    ctrl_rd[CTRL_SLP_DIS]        = cfg.sleep_disable;
    ctrl_rd[CTRL_FAULT]          = write_fault_flag;
    ctrl_rd[CTRL_UNUSED]         = 1'b0;
    ctrl_rd[CTRL_CS_LSB +: 2]    = cfg.clock_src;
    ctrl_rd[CTRL_MUX_LSB +: 2]   = cfg.multiplex_sel;
    phase_rd = 8'h00;
    phase_rd[PH_WAVE_B]          = cfg.waveform_b;
    phase_rd[PH_WA]              = write_allow;
    phase_rd[PH_PRE_LSB +: 4]    = cfg.prescale;
  end

  // Read data multiplexer
  always_comb begin
    prdata_next = 32'h0000_0000;
    unique case (kind)
      K_CTRL:     prdata_next[7:0] = ctrl_rd;
      K_PHASE:    prdata_next[7:0] = phase_rd;
      K_SE:       prdata_next[7:0] = group_present(se_grp) ? seg_en_reg[se_grp] : 8'h00;
      K_IRQ_ST:   prdata_next[IRQ_N-1:0] = irq_status;
      K_IRQ_MASK: prdata_next[IRQ_N-1:0] = irq_mask;
      K_PIX:      prdata_next[7:0] = group_present(pix_group(pidx)) ? mem_bus_rdata : 8'h00;
      default:    prdata_next = 32'h0000_0000;
    endcase
  end

  // Registered answer, loaded in the first access cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (access && !pready) begin
        prdata  <= apb_req.pwrite ? 32'h0000_0000 : prdata_next;
        pslverr <= (kind == K_NONE);
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Checks
  property ctrl_on_p;
    @(posedge clk) disable iff (rst)
      (wr_done && kind == K_CTRL) |=> (cfg.driver_on == $past(apb_req.pwdata[CTRL_ON]));
  endproperty

  seg_enable_a: assert property (@(posedge clk) disable iff (rst)
    (wr_done && kind == K_SE && se_grp == 2'd0)
      |=> segment_pin_assign[7:0] == $past(apb_req.pwdata[7:0]))
    else $error("segment enable write lost");

  pixel_index_a: assert property (@(posedge clk) disable iff (rst)
    pix_wr |-> (4'(pidx) == 4'((apb_req.paddr - OFF_PIX) / WORD_BYTES)) && pidx < 4'(PIX_REGS))
    else $error("pixel index decode wrong");

  pixel_view_a: assert property (@(posedge clk) disable iff (rst)
    pix_wr ##1 (ce && disp_idx == $past(pidx))
      |=> disp_pixels == $past(apb_req.pwdata[7:0], 2))
    else $error("display port does not show written pixels");

  driver_on_a: assert property (ctrl_on_p)
    else $error("driver enable not updated");

  sleep_run_a: assert property (@(posedge clk) disable iff (rst)
    (ce && cfg.driver_on && !cfg.sleep_disable && chip_sleep) |=> lcd_active)
    else $error("driver stopped in sleep");

  fault_clear_a: assert property (@(posedge clk) disable iff (rst)
    (wr_done && kind == K_CTRL && apb_req.pwdata[CTRL_FAULT] && !write_fault_flag)
      |=> !write_fault_flag)
    else $error("writing one set the fault flag");

  fault_set_a: assert property (@(posedge clk) disable iff (rst)
    fault_ev |=> write_fault_flag [*2] or (write_fault_flag ##1 1'b1))
    else $error("refused write did not flag");

  ctrl_read_a: assert property (@(posedge clk) disable iff (rst)
    (ce && access && !pready && !apb_req.pwrite && kind == K_CTRL)
      |=> prdata[CTRL_UNUSED] == 1'b0 && prdata[CTRL_MUX_LSB +: 2] == $past(cfg.multiplex_sel))
    else $error("control read layout wrong");

  phase_write_a: assert property (@(posedge clk) disable iff (rst)
    (wr_done && kind == K_PHASE)
      |=> cfg.prescale == $past(apb_req.pwdata[PH_PRE_LSB +: 4]))
    else $error("prescaler not updated");

  small_variant_a: assert property (@(posedge clk) disable iff (rst)
    (!LARGE && kind == K_PIX && pix_group(pidx) == 2'd2) |-> !pix_wr)
    else $error("absent pixel group written");

  apb_answer_a: assert property (@(posedge clk) disable iff (rst)
    (ce && access && !pready) |=> pready)
    else $error("APB answer late");

  cov_pix_write_c:  cover property (@(posedge clk) disable iff (rst) pix_wr);
  cov_fault_c:      cover property (@(posedge clk) disable iff (rst) fault_ev ##[1:20] irq);
  cov_sleep_c:      cover property (@(posedge clk) disable iff (rst)
    lcd_active && chip_sleep);
  cov_unmapped_c:   cover property (@(posedge clk) disable iff (rst) unmapped_ev);
endmodule

// ### panel_model.sv
// Far-side model of the waveform engine and glass: scans the pixel registers.
// Assumes the register bank answers on disp_pixels one edge after disp_idx.
`timescale 1ns/1ps
module panel_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control from the bench
  input  wire logic       block_writes,
  // Display port of the register bank
  output logic      [3:0] disp_idx,
  input  wire logic [7:0] disp_pixels,
  output logic            write_allow,
  // Last scanned frame, one byte per pixel register
  output logic      [7:0] frame [12]
);
  logic [3:0] prev_idx;

  // Scan index 3*common + group over all twelve registers
  always_ff @(posedge clk) begin
    if (rst) begin
      disp_idx <= 4'h0;
      prev_idx <= 4'h0;
    end else begin
      prev_idx <= disp_idx;
      disp_idx <= (disp_idx == 4'hb) ? 4'h0 : disp_idx + 4'h1;
      frame[prev_idx] <= disp_pixels;
    end
  end

  // Safe-write window, closed while the bench blocks it
  always_ff @(posedge clk) begin
    write_allow <= !block_writes;
  end
endmodule

// ### tb_lcd_regs.sv
// Testbench of the LCD register bank: APB master, scoreboard, panel model.
// Assumes the large variant at 10 MHz; ce is held high throughout.
`timescale 1ns/1ps
module tb_lcd_regs;
  import lcd_pkg::*;

  typedef struct {
    logic        rd;
    logic [31:0] data;
    logic        err;
  } exp_t;

  logic        clk;
  logic        rst;
  logic        ce;
  apb_req_t    req;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        chip_sleep;
  logic        write_allow;
  logic        block_writes;
  logic [3:0]  disp_idx;
  logic [7:0]  disp_pixels;
  lcd_cfg_t    cfg;
  logic        write_fault_flag;
  logic        lcd_active;
  logic [23:0] segment_pin_assign;
  logic        irq;
  logic [7:0]  frame [12];
  logic [7:0]  pix [12];
  logic [7:0]  se [3];
  exp_t        expq [$];
  exp_t        mon_e;
  int          num_errors;
  int          checks;
  int          cycles;
  integer      seed;

  lcd_regs #(.LARGE(1'b1)) u_lcd_regs (
    .clk(clk), .rst(rst), .ce(ce), .apb_req(req), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .chip_sleep(chip_sleep), .write_allow(write_allow),
    .disp_idx(disp_idx), .disp_pixels(disp_pixels), .cfg(cfg),
    .write_fault_flag(write_fault_flag), .lcd_active(lcd_active),
    .segment_pin_assign(segment_pin_assign), .irq(irq)
  );

  panel_model u_panel_model (
    .clk(clk), .rst(rst), .block_writes(block_writes), .disp_idx(disp_idx),
    .disp_pixels(disp_pixels), .write_allow(write_allow), .frame(frame)
  );

  // Clock generator
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic logic [31:0] cfgv(logic on, logic sd, logic [1:0] cs, logic [1:0] mux,
                                       logic wb, logic [3:0] pre);
    return {21'h0, on, sd, cs, mux, wb, pre};
  endfunction

  // One APB transfer; notes the expected answer, holds until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err);
    exp_t e;
    int   n;
    e.rd = !wr;
    e.data = d;
    e.err = err;
    expq.push_back(e);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      $display("Error at %0t: no pready", $time);
    end
  endtask

  // Release the bus and let registered outputs settle
  task automatic idle();
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Scoreboard: oldest note against each completed transfer
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (expq.size() == 0) begin
        num_errors++;
        $display("Error at %0t: unexpected response", $time);
      end else begin
        mon_e = expq.pop_front();
        check({31'h0, pslverr}, {31'h0, mon_e.err});
        if (mon_e.rd) check(prdata, mon_e.data);
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: timeout", $time);
      conclude();
    end
  end

  // Main sequence
  initial begin
    seed = 32'h921f;
    rst = 1'b1;
    ce = 1'b1;
    chip_sleep = 1'b0;
    block_writes = 1'b0;
    req = '0;
    num_errors = 0;
    checks = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values of control, phase, segment and pixel registers
    apb(1'b0, OFF_CTRL, 32'h03, 1'b0);
    apb(1'b0, OFF_PHASE, 32'h20, 1'b0);
    for (int i = 0; i < 3; i++) apb(1'b0, OFF_SE0 + 12'(4*i), 32'h0, 1'b0);
    for (int i = 0; i < 12; i++) apb(1'b0, OFF_PIX + 12'(4*i), 32'h0, 1'b0);
    idle();
    check(32'(cfg), cfgv(1'b0, 1'b0, 2'b00, 2'b11, 1'b0, 4'h0));
    check({31'h0, write_fault_flag}, 32'h0);
    $display("test reset done");
    // Control layout: fault bit and bit 4 cannot be set
    apb(1'b1, OFF_CTRL, 32'hff, 1'b0);
    apb(1'b0, OFF_CTRL, 32'hcf, 1'b0);
    idle();
    check(32'(cfg), cfgv(1'b1, 1'b1, 2'b11, 2'b11, 1'b0, 4'h0));
    apb(1'b1, OFF_CTRL, 32'hffffff02, 1'b0);
    apb(1'b0, OFF_CTRL, 32'h02, 1'b0);
    apb(1'b1, OFF_PHASE, 32'h8f, 1'b0);
    apb(1'b0, OFF_PHASE, 32'haf, 1'b0);
    idle();
    check(32'(cfg), cfgv(1'b0, 1'b0, 2'b00, 2'b10, 1'b1, 4'hf));
    $display("test control done");
    // Segment enables with random contents
    for (int i = 0; i < 3; i++) begin
      se[i] = 8'($random(seed));
      apb(1'b1, OFF_SE0 + 12'(4*i), {24'h0, se[i]}, 1'b0);
      apb(1'b0, OFF_SE0 + 12'(4*i), {24'h0, se[i]}, 1'b0);
    end
    idle();
    check({8'h0, segment_pin_assign}, {8'h0, se[2], se[1], se[0]});
    $display("test segments done");
    // Pixel map seen by the panel scan
    for (int i = 0; i < 12; i++) begin
      pix[i] = 8'($random(seed));
      apb(1'b1, OFF_PIX + 12'(4*i), {24'h0, pix[i]}, 1'b0);
    end
    for (int i = 0; i < 12; i++) apb(1'b0, OFF_PIX + 12'(4*i), {24'h0, pix[i]}, 1'b0);
    idle();
    repeat (30) @(posedge clk);
    for (int i = 0; i < 12; i++) check({24'h0, frame[i]}, {24'h0, pix[i]});
    $display("test pixels done");
    // Pixel write outside the safe window while on
    block_writes <= 1'b1;
    apb(1'b1, OFF_CTRL, 32'h82, 1'b0);
    apb(1'b1, OFF_PIX + 12'h010, {24'h0, ~pix[4]}, 1'b0);
    apb(1'b0, OFF_PIX + 12'h010, {24'h0, pix[4]}, 1'b0);
    apb(1'b0, OFF_CTRL, 32'ha2, 1'b0);
    apb(1'b0, OFF_PHASE, 32'h8f, 1'b0);
    idle();
    check({31'h0, irq}, 32'h0);
    apb(1'b1, OFF_IRQ_MASK, 32'h3, 1'b0);
    idle();
    check({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'ha2, 1'b0);
    apb(1'b0, OFF_CTRL, 32'ha2, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h82, 1'b0);
    apb(1'b0, OFF_CTRL, 32'h82, 1'b0);
    apb(1'b1, OFF_IRQ_ST, 32'h1, 1'b0);
    idle();
    check({31'h0, irq}, 32'h0);
    check({31'h0, write_fault_flag}, 32'h0);
    $display("test fault done");
    // Unmapped and unaligned accesses
    apb(1'b0, 12'h01c, 32'h0, 1'b1);
    apb(1'b1, 12'h002, 32'hff, 1'b1);
    apb(1'b0, OFF_CTRL, 32'h82, 1'b0);
    idle();
    check({31'h0, irq}, 32'h1);
    apb(1'b0, OFF_IRQ_ST, 32'h2, 1'b0);
    apb(1'b1, OFF_IRQ_ST, 32'h2, 1'b0);
    block_writes <= 1'b0;
    idle();
    check({31'h0, irq}, 32'h0);
    $display("test unmapped done");
    // Running through chip sleep
    chip_sleep <= 1'b1;
    idle();
    check({31'h0, lcd_active}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'hc2, 1'b0);
    idle();
    check({31'h0, lcd_active}, 32'h0);
    chip_sleep <= 1'b0;
    idle();
    check({31'h0, lcd_active}, 32'h1);
    apb(1'b1, OFF_CTRL, 32'h02, 1'b0);
    idle();
    check({31'h0, lcd_active}, 32'h0);
    $display("test sleep done");
    conclude();
  end
endmodule
